// [src/irq_regs_top.sv]
// Purpose: Pin-edge and power-good interrupt flag and mask registers on an AHB-Lite slave.
// Assumes: One clock, synchronous active-high reset acting as power-on reset.
// Notes: Zero-wait-state slave; reads return the byte in hrdata[7:0], upper bits zero.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module irq_regs_top
  import irq_regs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [REG_W-1:0] otp_pin_mask_i,
  input wire logic [PIN_N-1:0] pin_level_i,
  input wire logic [REGU_N-1:0] linreg_good_i,
  input wire logic [REGU_N-1:0] linreg_en_i,
  input wire logic [REGU_N-1:0] conv_good_i,
  input wire logic [REGU_N-1:0] conv_en_i,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Edge capture
  // ----------------------------------------------------------------
  event_if evt ();

  edge_capture u_edge_capture (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pin_level_i(pin_level_i),
    .linreg_good_i(linreg_good_i),
    .linreg_en_i(linreg_en_i),
    .conv_good_i(conv_good_i),
    .conv_en_i(conv_en_i),
    .evt(evt)
  );

  // Set requests in register bit order.
  logic [REG_W-1:0] pin_set;
  logic [REG_W-1:0] pg_set;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin_map
      assign pin_set[2*gi+PIN_RISE_OFS] = evt.pin_rise[gi];
      assign pin_set[2*gi+PIN_FALL_OFS] = evt.pin_fall[gi];
      assign pg_set[LINREG_LSB+gi] = evt.linreg_fall[gi];
      assign pg_set[CONV_LSB+gi] = evt.conv_fall[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  logic wr_pend;
  logic next_wr_pend;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] next_wr_idx;
  logic [31:0] next_hrdata;
  logic addr_take;
  logic addr_in_map;
  logic [IDX_W-1:0] addr_idx;

  logic [REG_W-1:0] pin_sts;
  logic [REG_W-1:0] pin_msk;
  logic [REG_W-1:0] pg_sts;
  logic [REG_W-1:0] pg_msk;

  assign addr_take = hsel_i & hready_i & htrans_i[HTRANS_ACTIVE_BIT];
  assign addr_idx = haddr_i[IDX_W+1:2];
  assign addr_in_map = (haddr_i[31:IDX_W+2] == '0) & (haddr_i[1:0] == WORD_LSB);

  always_comb begin
    next_wr_pend = addr_take & hwrite_i & addr_in_map;
    next_wr_idx = addr_idx;
    next_hrdata = RDATA_ZERO;
    if (addr_take && !hwrite_i && addr_in_map) begin
      unique case (addr_idx)
        PIN_STS_IDX: next_hrdata[REG_W-1:0] = pin_sts;
        PIN_MSK_IDX: next_hrdata[REG_W-1:0] = pin_msk;
        PG_STS_IDX: next_hrdata[REG_W-1:0] = pg_sts;
        PG_MSK_IDX: next_hrdata[REG_W-1:0] = pg_msk;
        default: next_hrdata = RDATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_idx <= '0;
      hrdata_o <= RDATA_ZERO;
      hreadyout_o <= 1'b1;
      hresp_o <= HRESP_OKAY;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      hrdata_o <= next_hrdata;
      hreadyout_o <= 1'b1;
      hresp_o <= HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [REG_W-1:0] wdata;
  logic wr_pin_sts;
  logic wr_pin_msk;
  logic wr_pg_sts;
  logic wr_pg_msk;
  logic [REG_W-1:0] next_pin_sts;
  logic [REG_W-1:0] next_pin_msk;
  logic [REG_W-1:0] next_pg_sts;
  logic [REG_W-1:0] next_pg_msk;
  logic next_irq;

  assign wdata = hwdata_i[REG_W-1:0];
  assign wr_pin_sts = wr_pend & (wr_idx == PIN_STS_IDX);
  assign wr_pin_msk = wr_pend & (wr_idx == PIN_MSK_IDX);
  assign wr_pg_sts = wr_pend & (wr_idx == PG_STS_IDX);
  assign wr_pg_msk = wr_pend & (wr_idx == PG_MSK_IDX);

  // A flag is cleared only by a 1 in its own bit, and a new event in the same cycle wins.
  always_comb begin
    next_pin_sts = pin_set | (pin_sts & ~({REG_W{wr_pin_sts}} & wdata));
    next_pg_sts = pg_set | (pg_sts & ~({REG_W{wr_pg_sts}} & wdata));
    next_pin_msk = wr_pin_msk ? wdata : pin_msk;
    next_pg_msk = wr_pg_msk ? wdata : pg_msk;
    // Mask 1 blocks, mask 0 passes.
    next_irq = |(next_pin_sts & ~next_pin_msk) | |(next_pg_sts & ~next_pg_msk);
  end

  // Reset acts as power-on reset; the pin mask loads its factory value.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_sts <= STS_RESET;
      pg_sts <= STS_RESET;
      pin_msk <= otp_pin_mask_i;
      pg_msk <= PG_MSK_RESET;
      irq_o <= 1'b0;
    end else begin
      pin_sts <= next_pin_sts;
      pg_sts <= next_pg_sts;
      pin_msk <= next_pin_msk;
      pg_msk <= next_pg_msk;
      irq_o <= next_irq;
    end
  end

endmodule : irq_regs_top

`default_nettype wire

// [pkg/irq_regs_pkg.sv]
// Purpose: Shared constants for the pin-edge and power-good interrupt register block.
// Assumes: AHB-Lite slave with 32-bit data, one aligned word per register.
// Notes: Register indices are kept as printed; the byte address is four times the index.
`default_nettype none

package irq_regs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned REG_W = 8;
  localparam int unsigned PIN_N = 4;
  localparam int unsigned REGU_N = 4;
  localparam int unsigned IDX_W = 8;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] PIN_STS_IDX = 8'h3B;
  localparam logic [IDX_W-1:0] PIN_MSK_IDX = 8'h3C;
  localparam logic [IDX_W-1:0] PG_STS_IDX = 8'h3D;
  localparam logic [IDX_W-1:0] PG_MSK_IDX = 8'h3E;
  localparam logic [1:0] WORD_LSB = 2'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] STS_RESET = 8'h00;
  localparam logic [REG_W-1:0] PG_MSK_RESET = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Pin-edge byte: pin (i+2) rise at bit 2i, fall at bit 2i+1.
  localparam int unsigned PIN_RISE_OFS = 0;
  localparam int unsigned PIN_FALL_OFS = 1;
  // Power-good byte: converters 1..4 in bits 3..0 order, linear regulators in 7..4.
  localparam int unsigned CONV_LSB = 0;
  localparam int unsigned LINREG_LSB = 4;

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : irq_regs_pkg

`default_nettype wire

// [pkg/event_if.sv]
// Purpose: Carries one-cycle edge events from the capture stage to the register file.
// Assumes: Single clock; every event is a pulse of one cycle.
// Notes: The source modport drives, the sink modport reads.
`timescale 1ns/1ps
`default_nettype none

interface event_if;
  import irq_regs_pkg::*;

  logic [PIN_N-1:0] pin_rise;
  logic [PIN_N-1:0] pin_fall;
  logic [REGU_N-1:0] linreg_fall;
  logic [REGU_N-1:0] conv_fall;

  modport source (
    output pin_rise,
    output pin_fall,
    output linreg_fall,
    output conv_fall
  );

  modport sink (
    input pin_rise,
    input pin_fall,
    input linreg_fall,
    input conv_fall
  );

endinterface : event_if

`default_nettype wire

// [src/edge_capture.sv]
// Purpose: Detects pin edges and enabled power-good falling edges as one-cycle events.
// Assumes: All inputs are synchronous to mclk_i.
// Notes: No event is raised in the first cycle after reset, while history is not yet valid.
`timescale 1ns/1ps
`default_nettype none

module edge_capture
  import irq_regs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [PIN_N-1:0] pin_level_i,
  input wire logic [REGU_N-1:0] linreg_good_i,
  input wire logic [REGU_N-1:0] linreg_en_i,
  input wire logic [REGU_N-1:0] conv_good_i,
  input wire logic [REGU_N-1:0] conv_en_i,
  event_if.source evt
);

  logic primed;
  logic next_primed;
  logic [PIN_N-1:0] pin_prev;
  logic [PIN_N-1:0] next_pin_prev;
  logic [REGU_N-1:0] linreg_prev;
  logic [REGU_N-1:0] next_linreg_prev;
  logic [REGU_N-1:0] conv_prev;
  logic [REGU_N-1:0] next_conv_prev;
  logic [PIN_N-1:0] next_pin_rise;
  logic [PIN_N-1:0] next_pin_fall;
  logic [REGU_N-1:0] next_linreg_fall;
  logic [REGU_N-1:0] next_conv_fall;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  always_comb begin
    next_primed = 1'b1;
    next_pin_prev = pin_level_i;
    next_linreg_prev = linreg_good_i;
    next_conv_prev = conv_good_i;
    next_pin_rise = {PIN_N{primed}} & pin_level_i & ~pin_prev;
    next_pin_fall = {PIN_N{primed}} & ~pin_level_i & pin_prev;
    // A drop while the regulator is disabled is not an event.
    next_linreg_fall = {REGU_N{primed}} & linreg_en_i & linreg_prev & ~linreg_good_i;
    next_conv_fall = {REGU_N{primed}} & conv_en_i & conv_prev & ~conv_good_i;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      primed <= 1'b0;
      pin_prev <= '0;
      linreg_prev <= '0;
      conv_prev <= '0;
      evt.pin_rise <= '0;
      evt.pin_fall <= '0;
      evt.linreg_fall <= '0;
      evt.conv_fall <= '0;
    end else begin
      primed <= next_primed;
      pin_prev <= next_pin_prev;
      linreg_prev <= next_linreg_prev;
      conv_prev <= next_conv_prev;
      evt.pin_rise <= next_pin_rise;
      evt.pin_fall <= next_pin_fall;
      evt.linreg_fall <= next_linreg_fall;
      evt.conv_fall <= next_conv_fall;
    end
  end

endmodule : edge_capture

`default_nettype wire

// [verification/irq_regs_top_sva.sv]
// Purpose: Port-level checks of the interrupt register block.
// Assumes: One clock, synchronous active-high reset, zero-wait AHB-Lite slave.
// Notes: Bound to irq_regs_top after the module.
`timescale 1ns/1ps
`default_nettype none

module irq_regs_sva (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic irq_o
);
  logic rd_take;
  assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_ready_high: assert property (hreadyout_o)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp_o)
    else $error("hresp not okay");
  a_upper_zero: assert property (hrdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_idle_rdata: assert property (!rd_take |=> hrdata_o == 32'h0)
    else $error("read data without a read");
  a_unmapped_zero: assert property (rd_take && haddr_i == 32'h0000_00FC |=>
    hrdata_o == 32'h0) else $error("unmapped read not zero");
  a_pgmask_reset: assert property ($past(rst_i) && rd_take && haddr_i == 32'h0000_00F8
    |=> hrdata_o[7:0] == 8'hFF) else $error("power-good mask not all ones");
  a_irq_quiet: assert property ($fell(rst_i) |-> !irq_o [*2])
    else $error("interrupt right after reset");
  a_irq_drop: assert property ($fell(irq_o) |-> $past(hsel_i && htrans_i[1] && hwrite_i, 2))
    else $error("interrupt dropped without a write");
endmodule : irq_regs_sva

bind irq_regs_top irq_regs_sva i_sva (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .irq_o(irq_o));

`default_nettype wire

// [verification/irq_regs_top_tb.sv]
// Purpose: Self-checking bench for the interrupt register block.
// Assumes: Bench is the only bus master; hready follows hreadyout.
// Notes: Status bit j of the power-good byte maps to bit j of the good vector.
`timescale 1ns/1ps
`default_nettype none

module irq_regs_top_tb;
  import irq_regs_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] otp = 8'h00;
  logic [3:0] pins = 4'h0;
  logic [7:0] good = 8'hFF;
  logic [7:0] en = 8'hFF;
  logic [31:0] hrdata;
  logic hready;
  logic irq;
  logic [7:0] rd;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  irq_regs_top i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
    .otp_pin_mask_i(otp), .pin_level_i(pins), .linreg_good_i(good[7:4]),
    .linreg_en_i(en[7:4]), .conv_good_i(good[3:0]), .conv_en_i(en[3:0]), .irq_o(irq));

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end

  task results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge mclk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge mclk_i); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus

  task rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rdchk

  task irqchk(input logic exp);
    @(posedge mclk_i);
    chk({7'h0, irq}, {7'h0, exp});
  endtask : irqchk

  task t_reset(input logic [7:0] v);
    otp <= v;
    rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdchk(PG_MSK_IDX, PG_MSK_RESET);
    rdchk(PG_STS_IDX, STS_RESET);
    rdchk(PIN_STS_IDX, STS_RESET);
    rdchk(PIN_MSK_IDX, v);
    irqchk(1'b0);
    bus(1'b1, PIN_MSK_IDX, ~v);
    rdchk(PIN_MSK_IDX, ~v);
    bus(1'b1, PG_MSK_IDX, 8'h00);
    rdchk(PG_MSK_IDX, 8'h00);
    bus(1'b1, 8'h3F, 8'hFF);
    rdchk(8'h3F, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task t_pins;
    bus(1'b1, PIN_MSK_IDX, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      pins <= 4'h1 << i;
      repeat (3) @(posedge mclk_i);
      rdchk(PIN_STS_IDX, 8'h01 << (2 * i));
      pins <= 4'h0;
      repeat (3) @(posedge mclk_i);
      rdchk(PIN_STS_IDX, 8'h03 << (2 * i));
      irqchk(1'b0);
      bus(1'b1, PIN_MSK_IDX, ~(8'h02 << (2 * i)));
      irqchk(1'b1);
      bus(1'b1, PIN_STS_IDX, 8'h01 << (2 * i));
      rdchk(PIN_STS_IDX, 8'h02 << (2 * i));
      bus(1'b1, PIN_STS_IDX, 8'h02 << (2 * i));
      irqchk(1'b0);
    end
    $display("test pins done");
  endtask : t_pins

  task t_pg;
    bus(1'b1, PG_MSK_IDX, 8'hFF);
    for (int j = 0; j < 8; j++) begin
      good <= ~(8'h01 << j);
      repeat (3) @(posedge mclk_i);
      rdchk(PG_STS_IDX, 8'h01 << j);
      irqchk(1'b0);
      bus(1'b1, PG_MSK_IDX, ~(8'h01 << j));
      irqchk(1'b1);
      bus(1'b1, PG_STS_IDX, 8'h01 << j);
      rdchk(PG_STS_IDX, 8'h00);
      bus(1'b1, PG_MSK_IDX, 8'hFF);
      good <= 8'hFF;
      repeat (3) @(posedge mclk_i);
    end
    rdchk(PG_STS_IDX, 8'h00);
    en <= 8'h00;
    @(posedge mclk_i);
    good <= 8'h00;
    repeat (3) @(posedge mclk_i);
    rdchk(PG_STS_IDX, 8'h00);
    en <= 8'hFF;
    good <= 8'hFF;
    repeat (3) @(posedge mclk_i);
    good <= 8'h00;
    repeat (3) @(posedge mclk_i);
    rdchk(PG_STS_IDX, 8'hFF);
    $display("test power-good done");
  endtask : t_pg

  // ----------------------------------------------------------------
  // Main sequence and hang limit
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      results;
    end
  end

  initial begin
    t_reset(8'hA5);
    t_pins;
    t_pg;
    t_reset(8'h3C);
    results;
  end
endmodule : irq_regs_top_tb

`default_nettype wire
